// File: src/udr_pkg.sv
/*
  constants for the uart data word and receive status block.
  assumes a 32-bit apb with word-aligned registers.
*/
package udr_pkg;
  localparam logic [11:0] UDR_OFS_DATA = 12'h000;
  localparam logic [11:0] UDR_OFS_RSR = 12'h004;
  localparam logic [11:0] UDR_OFS_CTRL = 12'h008;
  localparam logic [11:0] UDR_OFS_STAT = 12'h00c;
  // control word fields
  localparam int UDR_CTL_EN = 0;
  localparam int UDR_CTL_FEN = 1;
  localparam int UDR_CTL_PEN = 2;
  localparam int UDR_CTL_EPS = 3;
  localparam int UDR_CTL_SPS = 4;
  localparam logic [4:0] UDR_CTRL_RST = 5'h00;
  // data word fields
  localparam int UDR_DW_FE = 8;
  localparam int UDR_DW_PE = 9;
  localparam int UDR_DW_BE = 10;
  localparam int UDR_DW_OE = 11;
  // status register fields
  localparam int UDR_RS_FE = 0;
  localparam int UDR_RS_PE = 1;
  localparam int UDR_RS_BE = 2;
  localparam int UDR_RS_OE = 3;
  localparam logic [3:0] UDR_RSR_RST = 4'h0;
  // bit time in clock cycles, default 125 MHz / 115200
  localparam int UDR_CLK_HZ = 125000000;
  localparam int UDR_BAUD = 115200;
  localparam int UDR_BIT_CYC = UDR_CLK_HZ / UDR_BAUD;
  localparam int UDR_FIFO_DEPTH = 32;
  typedef enum logic [4:0] {
    UDR_S_IDLE = 5'b00001,
    UDR_S_START = 5'b00010,
    UDR_S_DATA = 5'b00100,
    UDR_S_PAR = 5'b01000,
    UDR_S_STOP = 5'b10000
  } udr_state_t;
endpackage

// File: src/udr_core.sv
/*
  uart data path: tx fifo/holding, tx serialiser, rx sampler, rx fifo
  with error flags, receive status register and apb slave.
  assumes a serial line partner at the programmed bit time.
*/
// Operation
// - fifo mode pushes data writes to tx fifo
// - non-fifo mode uses single tx holding slot
// - send start, data, optional parity, stop
// - fifo mode stores byte plus three flags
// - non-fifo mode uses single rx holding slot
// - data read maps byte and flags bits
// - overrun bit set when rx store full
// - break when line low past full frame
// - break loads one zero char, waits mark
// - flags travel with the fifo top entry
// - parity error against even/stick selection
// - framing error when stop bit low
// - disable finishes current character first
// - status overrun sets immediately
// - other status bits update on data read
// - any status write clears all errors
// - status bits oe3 be2 pe1 fe0
// - status register resets to zero
// - overrun keeps fifo, drops shift char
// - non-fifo stores have depth one
`timescale 1ns/1ps
module udr_core
  import udr_pkg::*;
#(
  parameter int DEPTH = UDR_FIFO_DEPTH,
  parameter int BIT_CYC = UDR_BIT_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic RXD_I,
  output logic TXD_O
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(BIT_CYC * 12 + 1);

  logic wr_acc, rd_acc;
  logic [4:0] ctrl_q;
  logic [7:0] txf_mem [DEPTH];
  logic [11:0] rxf_mem [DEPTH];
  logic [AW:0] txw_q, txr_q, rxw_q, rxr_q;
  logic [AW:0] tx_cnt, rx_cnt, tx_cap, rx_cap;
  logic tx_full, rx_full, tx_empty, rx_empty;
  logic [3:0] rsr_q;
  logic [31:0] prdata_q;
  logic rx_pop, tx_push;

  assign PREADY_O = 1'b1;
  assign PSLVERR_O = 1'b0;
  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_acc = PSEL_I && PENABLE_I && !PWRITE_I;
  assign PRDATA_O = prdata_q;

  // depth one when fifos are off
  assign tx_cap = ctrl_q[UDR_CTL_FEN] ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign rx_cap = ctrl_q[UDR_CTL_FEN] ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign tx_cnt = txw_q - txr_q;
  assign rx_cnt = rxw_q - rxr_q;
  assign tx_full = tx_cnt >= tx_cap;
  assign rx_full = rx_cnt >= rx_cap;
  assign tx_empty = tx_cnt == '0;
  assign rx_empty = rx_cnt == '0;
  // writes to a full store are dropped
  assign tx_push = wr_acc && PADDR_I == UDR_OFS_DATA && !tx_full;
  assign rx_pop = rd_acc && PADDR_I == UDR_OFS_DATA && !rx_empty;

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      ctrl_q <= UDR_CTRL_RST;
    else if (wr_acc && PADDR_I == UDR_OFS_CTRL)
      ctrl_q <= PWDATA_I[4:0];
  end

  // transmit store: fifo or one-deep holding slot at the write pointer
  always_ff @(posedge REF_CLK_I)
  begin
    if (tx_push)
      txf_mem[txw_q[AW-1:0]] <= PWDATA_I[7:0];
  end

  // ---- transmitter
  udr_state_t txs_q;
  logic [CW-1:0] txc_q;
  logic [2:0] txb_q;
  logic [7:0] txsh_q;
  logic txpar_q;
  logic tx_tick;
  assign tx_tick = txc_q == CW'(BIT_CYC - 1);

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      txw_q <= '0;
    else if (tx_push)
      txw_q <= txw_q + 1'b1;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      txs_q <= UDR_S_IDLE;
      txc_q <= '0;
      txb_q <= 3'h0;
      txsh_q <= 8'h00;
      txpar_q <= 1'b0;
      txr_q <= '0;
      TXD_O <= 1'b1;
    end
    else
    begin
      txc_q <= (txs_q == UDR_S_IDLE || tx_tick) ? '0 : txc_q + 1'b1;
      case (txs_q)
        UDR_S_IDLE:
          // disable only gates the next start, never a frame in flight
          if (ctrl_q[UDR_CTL_EN] && !tx_empty)
          begin
            txsh_q <= txf_mem[txr_q[AW-1:0]];
            txr_q <= txr_q + 1'b1;
            txs_q <= UDR_S_START;
            TXD_O <= 1'b0;
          end
        UDR_S_START:
          if (tx_tick)
          begin
            txs_q <= UDR_S_DATA;
            TXD_O <= txsh_q[0];
            txpar_q <= txsh_q[0];
            txb_q <= 3'h0;
          end
        UDR_S_DATA:
          if (tx_tick)
          begin
            if (txb_q == 3'h7)
            begin
              if (ctrl_q[UDR_CTL_PEN])
              begin
                txs_q <= UDR_S_PAR;
                TXD_O <= par_bit(txpar_q, ctrl_q);
              end
              else
              begin
                txs_q <= UDR_S_STOP;
                TXD_O <= 1'b1;
              end
            end
            else
            begin
              txb_q <= txb_q + 1'b1;
              TXD_O <= txsh_q[txb_q + 3'h1];
              txpar_q <= txpar_q ^ txsh_q[txb_q + 3'h1];
            end
          end
        UDR_S_PAR:
          if (tx_tick)
          begin
            txs_q <= UDR_S_STOP;
            TXD_O <= 1'b1;
          end
        UDR_S_STOP:
          if (tx_tick)
            txs_q <= UDR_S_IDLE;
        default:
          txs_q <= UDR_S_IDLE;
      endcase
    end
  end

  // parity bit from data xor and even/stick selection
  function automatic logic par_bit(input logic x, input logic [4:0] c);
    if (c[UDR_CTL_SPS])
      par_bit = !c[UDR_CTL_EPS];
    else
      par_bit = c[UDR_CTL_EPS] ? x : !x;
  endfunction

  // ---- receiver
  logic rx_m_q, rx_s_q;
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end
    else
    begin
      rx_m_q <= RXD_I;
      rx_s_q <= rx_m_q;
    end
  end

  udr_state_t rxs_q;
  logic [CW-1:0] rxc_q;
  logic [2:0] rxb_q;
  logic [7:0] rxsh_q;
  logic rxpar_q, rx_pe_q, rx_wait_q, rx_done, pend_q;
  logic [11:0] pend_word_q;
  logic [CW-1:0] low_q;
  logic [11:0] rx_word;
  logic rx_brk, rx_fe;
  logic ovr_q;

  // full frame: start, 8 data, parity if enabled, stop
  assign rx_brk = low_q > CW'(BIT_CYC * (ctrl_q[UDR_CTL_PEN] ? 11 : 10));
  assign rx_fe = !rx_s_q;
  assign rx_done = rxs_q == UDR_S_STOP && rxc_q == CW'(BIT_CYC/2);

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      low_q <= '0;
    else if (rx_s_q)
      low_q <= '0;
    else if (!rx_brk)
      low_q <= low_q + 1'b1;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      rxs_q <= UDR_S_IDLE;
      rxc_q <= '0;
      rxb_q <= 3'h0;
      rxsh_q <= 8'h00;
      rxpar_q <= 1'b0;
      rx_pe_q <= 1'b0;
    end
    else
    begin
      rxc_q <= (rxc_q == CW'(BIT_CYC - 1)) ? '0 : rxc_q + 1'b1;
      case (rxs_q)
        UDR_S_IDLE:
        begin
          rxc_q <= '0;
          // no new char while a break waits for marking
          if (ctrl_q[UDR_CTL_EN] && !rx_s_q && !rx_wait_q && !pend_q)
            rxs_q <= UDR_S_START;
        end
        UDR_S_START:
          if (rxc_q == CW'(BIT_CYC/2))
          begin
            rxs_q <= rx_s_q ? UDR_S_IDLE : UDR_S_DATA;
            rxb_q <= 3'h0;
            rxpar_q <= 1'b0;
          end
        UDR_S_DATA:
          if (rxc_q == CW'(BIT_CYC/2))
          begin
            rxsh_q <= {rx_s_q, rxsh_q[7:1]};
            rxpar_q <= rxpar_q ^ rx_s_q;
            rxb_q <= rxb_q + 1'b1;
            if (rxb_q == 3'h7)
              rxs_q <= ctrl_q[UDR_CTL_PEN] ? UDR_S_PAR : UDR_S_STOP;
          end
        UDR_S_PAR:
          if (rxc_q == CW'(BIT_CYC/2))
          begin
            rx_pe_q <= par_bit(rxpar_q, ctrl_q) != rx_s_q;
            rxs_q <= UDR_S_STOP;
          end
        UDR_S_STOP:
          if (rx_done)
          begin
            rxs_q <= UDR_S_IDLE;
            rx_pe_q <= 1'b0;
          end
        default:
          rxs_q <= UDR_S_IDLE;
      endcase
    end
  end

  // break: one zero char, then wait for the line to go high
  logic brk_ev;
  assign brk_ev = rx_brk && !rx_wait_q;
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      rx_wait_q <= 1'b0;
    else if (brk_ev)
      rx_wait_q <= 1'b1;
    else if (rx_s_q)
      rx_wait_q <= 1'b0;
  end

  // a low stop may be the front of a break: hold that char until the
  // line settles, so a break still leaves one zero entry only
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      pend_q <= 1'b0;
    else if (rx_done && rx_fe && !rx_brk)
      pend_q <= 1'b1;
    else if (brk_ev || rx_s_q)
      pend_q <= 1'b0;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      pend_word_q <= 12'h000;
    else if (rx_done)
      pend_word_q <= {2'b00, rx_pe_q, 1'b1, rxsh_q};
  end

  logic rx_ev, rx_store;
  assign rx_ev = brk_ev || (rx_done && !rx_fe && !rx_brk)
                 || (pend_q && rx_s_q && !brk_ev);
  assign rx_store = rx_ev && !rx_full;
  assign rx_word = brk_ev ? {1'b0, 1'b1, 1'b0, 1'b1, 8'h00}
                 : pend_q ? pend_word_q
                 : {1'b0, 1'b0, rx_pe_q, rx_fe, rxsh_q};

  always_ff @(posedge REF_CLK_I)
  begin
    if (rx_store)
      rxf_mem[rxw_q[AW-1:0]] <= rx_word;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      rxw_q <= '0;
    else if (rx_store)
      rxw_q <= rxw_q + 1'b1;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      rxr_q <= '0;
    else if (rx_pop)
      rxr_q <= rxr_q + 1'b1;
  end

  // overrun in the data word: held until a char fits again
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      ovr_q <= 1'b0;
    else if (rx_ev && rx_full)
      ovr_q <= 1'b1;
    else if (rx_store)
      ovr_q <= 1'b0;
  end

  // status register; set beats the clear
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      rsr_q <= UDR_RSR_RST;
    else
    begin
      if (wr_acc && PADDR_I == UDR_OFS_RSR)
        rsr_q <= 4'h0;
      if (rx_pop)
        rsr_q[2:0] <= {rxf_mem[rxr_q[AW-1:0]][UDR_DW_BE],
                       rxf_mem[rxr_q[AW-1:0]][UDR_DW_PE],
                       rxf_mem[rxr_q[AW-1:0]][UDR_DW_FE]};
      if (rx_ev && rx_full)
        rsr_q[UDR_RS_OE] <= 1'b1;
    end
  end

  // read data registered in the setup phase
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      prdata_q <= 32'h0;
    else if (PSEL_I && !PENABLE_I && !PWRITE_I)
    begin
      case (PADDR_I)
        UDR_OFS_DATA:
          prdata_q <= rx_empty ? 32'h0 :
            {20'h0, ovr_q, rxf_mem[rxr_q[AW-1:0]][10:0]};
        UDR_OFS_RSR:
          prdata_q <= {28'h0, rsr_q};
        UDR_OFS_CTRL:
          prdata_q <= {27'h0, ctrl_q};
        UDR_OFS_STAT:
          prdata_q <= {28'h0, txs_q != UDR_S_IDLE, tx_full, rx_empty,
                       rx_full};
        default:
          prdata_q <= 32'h0;
      endcase
    end
  end

  rsr_clear_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    wr_acc && PADDR_I == UDR_OFS_RSR && !(rx_ev && rx_full) && !rx_pop
    |=> rsr_q == 4'h0) else $error("status not cleared");
  ovr_set_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    rx_ev && rx_full |=> rsr_q[UDR_RS_OE] && ovr_q)
    else $error("overrun not flagged");
  ovr_keep_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    rx_ev && rx_full |=> $stable(rxw_q))
    else $error("fifo written on overrun");
  pop_adv_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    rx_pop |=> rxr_q == $past(rxr_q) + 1'b1)
    else $error("read did not pop");
  depth_one_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    !ctrl_q[UDR_CTL_FEN] |-> rx_cnt <= 1 && tx_cnt <= 1)
    else $error("depth one exceeded");
  start_bit_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    txs_q == UDR_S_IDLE && $past(txs_q) == UDR_S_IDLE
    && ctrl_q[UDR_CTL_EN] && !tx_empty |=> !TXD_O [*2])
    else $error("no start bit");
  brk_wait_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    rx_wait_q |-> rxs_q == UDR_S_IDLE)
    else $error("break wait broken");
  brk_word_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    brk_ev && !rx_full |=> rxf_mem[$past(rxw_q[AW-1:0])][7:0] == 8'h00)
    else $error("break char not zero");
  c_tx_a: cover property (@(posedge REF_CLK_I) tx_push);
  c_rx_a: cover property (@(posedge REF_CLK_I) rx_store);
  c_ovr_a: cover property (@(posedge REF_CLK_I) rx_ev && rx_full);
  c_brk_a: cover property (@(posedge REF_CLK_I) brk_ev);
endmodule

// File: tb/udr_line_model.sv
/*
  serial line partner: sends frames to the receiver, decodes frames
  from the transmitter. assumes 8 data bits and the dut bit time.
*/
`timescale 1ns/1ps
module udr_line_model #(
  parameter int BIT_CYC = 8
) (
  input wire logic clk_i,
  input wire logic par_en_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic [9:0] cap_o,
  output logic cap_v_o
);
  logic [9:0] sh;
  initial
  begin
    rxd_o = 1'b1;
    cap_o = '0;
    cap_v_o = 1'b0;
  end
  // idle gap after each frame so the next start edge is clean
  task automatic send(input logic [7:0] d, input logic p_en,
                      input logic p, input logic stp);
    logic [10:0] f;
    f = p_en ? {stp, p, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < (p_en ? 11 : 10); i++)
    begin
      rxd_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge clk_i);
  endtask
  // low well past an 11 bit frame
  task automatic brk();
    rxd_o <= 1'b0;
    repeat (13 * BIT_CYC) @(posedge clk_i);
    rxd_o <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge clk_i);
  endtask
  // mid-bit sampling; stop bit lands in bit 9
  initial forever
  begin
    @(negedge txd_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < (par_en_i ? 10 : 9); i++)
    begin
      repeat (BIT_CYC) @(posedge clk_i);
      sh[i] = txd_i;
    end
    cap_o <= par_en_i ? sh : {sh[8], 1'b0, sh[7:0]};
    cap_v_o <= 1'b1;
    @(posedge clk_i);
    cap_v_o <= 1'b0;
  end
endmodule

// File: tb/udr_core_test.sv
/*
  self-checking bench for the uart data word and receive status block.
  assumes the line partner model and a zero wait apb slave.
*/
`timescale 1ns/1ps
module udr_core_test;
  import udr_pkg::*;
  localparam int BC = 8;
  localparam int DP = 4;
  logic clk, rst_b, psel, pena, pwr, rxd, txd, prdy, cap_v;
  logic [11:0] paddr;
  logic [31:0] pwd, prd;
  logic [9:0] cap;
  logic [4:0] ctl;
  logic [7:0] d;
  logic [7:0] b [DP+1];
  logic [4:0] modes [5] = '{5'h01, 5'h05, 5'h0d, 5'h15, 5'h1d};
  logic [31:0] rd_q [$];
  logic [9:0] tx_q [$];
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  udr_core #(.DEPTH(DP), .BIT_CYC(BC)) u_dut (.REF_CLK_I(clk),
    .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pena), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
    .PSLVERR_O(), .RXD_I(rxd), .TXD_O(txd));
  udr_line_model #(.BIT_CYC(BC)) u_line (.clk_i(clk),
    .par_en_i(ctl[UDR_CTL_PEN]), .txd_i(txd), .rxd_o(rxd), .cap_o(cap),
    .cap_v_o(cap_v));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop();
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp_reg(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_frm(input logic [9:0] e, input logic [9:0] g);
    cmp_reg({22'h0, e}, {22'h0, g});
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] v);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= v;
    @(posedge clk);
    pena <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    psel <= 1'b0;
    pena <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, $urandom);
  endtask
  // disable first, so no half-programmed frame goes out
  task automatic setc(input logic [4:0] c);
    apb(1'b1, UDR_OFS_CTRL, 32'h0);
    ctl <= c;
    apb(1'b1, UDR_OFS_CTRL, {27'h0, c});
  endtask
  function automatic logic par(input logic [7:0] v, input logic [4:0] c);
    if (c[UDR_CTL_SPS])
      return !c[UDR_CTL_EPS];
    return c[UDR_CTL_EPS] ? ^v : ~^v;
  endfunction
  task automatic tx(input logic [7:0] v);
    tx_q.push_back({1'b1, ctl[UDR_CTL_PEN] & par(v, ctl), v});
    apb(1'b1, UDR_OFS_DATA, {24'h0, v});
  endtask
  task automatic drain();
    wait (tx_q.size() == 0);
    repeat (BC) @(posedge clk);
  endtask
  // n+1 chars into a store of n, entry 1 with bad parity
  task automatic ovr(input int n);
    apb(1'b1, UDR_OFS_RSR, $urandom);
    for (int i = 0; i <= n; i++)
    begin
      b[i] = 8'($urandom);
      u_line.send(b[i], 1'b1, par(b[i], ctl) ^ (i == 1), 1'b1);
    end
    rd(UDR_OFS_RSR, 32'h8);
    for (int i = 0; i < n; i++)
      rd(UDR_OFS_DATA, {20'h0, (i == 1) ? 4'ha : 4'h8, b[i]});
    rd(UDR_OFS_DATA, 32'h0);
    apb(1'b1, UDR_OFS_RSR, $urandom);
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop();
    end
    if (psel && pena && prdy === 1'b1 && !pwr)
      cmp_reg(rd_q.pop_front(), prd);
    if (cap_v === 1'b1)
      cmp_frm(tx_q.pop_front(), cap);
  end
  initial
  begin
    void'($urandom(32'h1aa2));
    {psel, pena, pwr} = 3'h0;
    paddr = 12'h000;
    pwd = 32'h0;
    ctl = 5'h00;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(UDR_OFS_RSR, 32'h0);
    rd(12'h010, 32'h0);
    foreach (modes[i])
    begin
      setc(modes[i]);
      tx(8'($urandom));
      drain();
    end
    setc(5'h03);
    repeat (3) tx(8'($urandom));
    drain();
    tx(8'($urandom));
    repeat (2 * BC) @(posedge clk);
    apb(1'b1, UDR_OFS_CTRL, 32'h0);
    drain();
    setc(5'h0d);
    d = 8'($urandom);
    u_line.send(d, 1'b1, par(d, ctl), 1'b1);
    rd(UDR_OFS_DATA, {24'h0, d});
    rd(UDR_OFS_DATA, 32'h0);
    u_line.send(d, 1'b1, !par(d, ctl), 1'b1);
    rd(UDR_OFS_DATA, {20'h0, 4'h2, d});
    rd(UDR_OFS_RSR, 32'h2);
    apb(1'b1, UDR_OFS_RSR, $urandom);
    u_line.send(d, 1'b1, par(d, ctl), 1'b0);
    rd(UDR_OFS_RSR, 32'h0);
    rd(UDR_OFS_DATA, {20'h0, 4'h1, d});
    rd(UDR_OFS_RSR, 32'h1);
    u_line.brk();
    rd(UDR_OFS_DATA, 32'h500);
    rd(UDR_OFS_DATA, 32'h0);
    rd(UDR_OFS_RSR, 32'h5);
    ovr(1);
    setc(5'h0f);
    ovr(DP);
    u_line.send(d, 1'b1, par(d, ctl), 1'b1);
    rd(UDR_OFS_DATA, {24'h0, d});
    report_and_stop();
  end
endmodule
